// ### verilog/fpg_supervisor_regs.vh
// Register codes, field positions, reset values and timing constants of the supervisor.
// Assumes a 100 MHz core clock and commands already decoded from the management bus.
`ifndef FPG_SUPERVISOR_REGS_VH
`define FPG_SUPERVISOR_REGS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FPG_CMD_VOUT_COMMAND 8'h21
`define FPG_CMD_VOUT_SCALE_LOOP 8'h29
`define FPG_CMD_OV_RESPONSE 8'h41
`define FPG_CMD_OT_RESPONSE 8'h50
`define FPG_CMD_NEG_LIMIT 8'hd5
`define FPG_CMD_VALLEY_LIMIT 8'hd7
`define FPG_CMD_OUT_CTRL 8'he1
`define FPG_CMD_PROTECT_CFG 8'he2
`define FPG_CMD_FAULT_STATUS 8'he3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPG_NEG_LIMIT_SEL_BIT 2
`define FPG_NEG_BLANK_SEL_BIT 3
`define FPG_RESP_LATCH_BIT 7
`define FPG_PROT_OC_LATCH_BIT 0
`define FPG_PROT_UV_LATCH_BIT 1
`define FPG_ST_OC 0
`define FPG_ST_UV 1
`define FPG_ST_OV 2
`define FPG_ST_OT 3
`define FPG_ST_LOCKOUT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPG_RST_VOUT_MV 16'h0258
`define FPG_RST_SCALE 16'h8000
`define FPG_RST_OV_RESP 8'h80
`define FPG_RST_OT_RESP 8'h00
`define FPG_RST_NEG_LIMIT 8'h00
`define FPG_RST_VALLEY 8'h40
`define FPG_RST_OUT_CTRL 8'h00
`define FPG_RST_PROTECT 8'h00

// ----------------------------------------------------------------
// Reference default and limits in millivolts and scale fraction bits
// ----------------------------------------------------------------
`define FPG_VREF_DEF_MV 10'h258
`define FPG_VREF_MIN_MV 10'h1f4
`define FPG_VREF_MAX_MV 10'h2a0
`define FPG_SCALE_FRAC 15

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPG_CLK_MHZ 100
`define FPG_OC_TRIP_CYCLES 5'h1f
`define FPG_SS_TIME_US 1000
`define FPG_HICCUP_TIME_US 2000
`define FPG_PG_STEP_US 1000
`define FPG_NEG_BLANK_SHORT_NS 100
`define FPG_NEG_BLANK_LONG_NS 200
`define FPG_NEG_BLANK_SHORT_CYC 5'h0a
`define FPG_NEG_BLANK_LONG_CYC 5'h14

`endif

// ### verilog/fpg_sync.v
// Two-flip-flop synchronisers for a group of asynchronous inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ns
module fpg_sync #(
  parameter W = 1
) (
  input wire clock_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule

// ### verilog/fpg_timer.v
// Loadable down-counter that gives a one-cycle done pulse at expiry.
// Assumes load_i is a one-cycle request from logic on the same clock.
`timescale 1ns/1ns
module fpg_timer (
  input wire clock_i,
  input wire rst_i,
  input wire load_i,
  input wire abort_i,
  input wire [23:0] count_i,
  output wire done_o
);

  reg [23:0] cnt_q;
  reg busy_q;
  reg done_q;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 24'h000000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort_i) begin
        busy_q <= 1'b0;
      end else if (load_i) begin
        cnt_q <= count_i;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= 24'h000001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h000001;
        end
      end
    end
  end

  assign done_o = done_q;

endmodule

// ### verilog/fpg_supervisor.v
// Protection and power-good supervisor of a buck power module.
// Assumes comparator levels arrive asynchronously from the power stage and that decoded
// management commands arrive on the core clock.
`timescale 1ns/1ns
`include "fpg_supervisor_regs.vh"
module fpg_supervisor #(
  parameter SS_CYCLES = `FPG_SS_TIME_US * `FPG_CLK_MHZ,
  parameter HICCUP_CYCLES = `FPG_HICCUP_TIME_US * `FPG_CLK_MHZ,
  parameter PG_STEP_CYCLES = `FPG_PG_STEP_US * `FPG_CLK_MHZ
) (
  input wire clock_i,
  input wire rst_i,
  input wire sw_clk_i,
  input wire ls_on_i,
  input wire hs_on_i,
  input wire oc_cmp_i,
  input wire neg_cmp_i,
  input wire uv_cmp_i,
  input wire ov_cmp_i,
  input wire sink_cmp_i,
  input wire ot_cmp_i,
  input wire pg_on_cmp_i,
  input wire lockout_i,
  input wire enable_pin_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_data_i,
  output reg [15:0] rd_data_o,
  output reg rd_valid_o,
  output reg switching_en_o,
  output reg soft_start_o,
  output reg hs_allow_o,
  output reg ls_force_off_o,
  output reg output_sink_state_o,
  output reg neg_limit_sel_o,
  output reg [7:0] valley_limit_o,
  output reg [9:0] vref_mv_o,
  output reg power_ok_o,
  output reg power_ok_oe_o,
  output reg [4:0] fault_status_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_OFF = 3'b000;
  localparam ST_SS = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_HICCUP = 3'b011;
  localparam ST_LATCH = 3'b100;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  wire [11:0] sync_w;
  fpg_sync #(.W(12)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({enable_pin_i, lockout_i, pg_on_cmp_i, ot_cmp_i, sink_cmp_i, ov_cmp_i,
              uv_cmp_i, neg_cmp_i, oc_cmp_i, hs_on_i, ls_on_i, sw_clk_i}),
    .sync_o(sync_w)
  );
  wire sw_s = sync_w[0];
  wire ls_s = sync_w[1];
  wire hs_s = sync_w[2];
  wire oc_s = sync_w[3];
  wire neg_s = sync_w[4];
  wire uv_s = sync_w[5];
  wire ov_s = sync_w[6];
  wire sink_s = sync_w[7];
  wire ot_s = sync_w[8];
  wire pgon_s = sync_w[9];
  wire lock_s = sync_w[10];
  wire en_s = sync_w[11];

  reg sw_prev_q;
  reg ls_prev_q;
  reg hs_prev_q;
  wire sw_edge = sw_s & ~sw_prev_q;
  wire ls_edge = ls_s & ~ls_prev_q;
  wire hs_edge = hs_s & ~hs_prev_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [15:0] vout_mv_q;
  reg [15:0] scale_q;
  reg [7:0] ov_resp_q;
  reg [7:0] ot_resp_q;
  reg [7:0] neg_cfg_q;
  reg [7:0] valley_q;
  reg [7:0] out_ctrl_q;
  reg [7:0] protect_q;
  reg scale_seen_q;
  reg pmbus_ref_q;

  function wr_hit;
    input [7:0] code;
    begin
      wr_hit = cmd_wr_i && (cmd_code_i == code);
    end
  endfunction

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vout_mv_q <= `FPG_RST_VOUT_MV;
      scale_q <= `FPG_RST_SCALE;
      ov_resp_q <= `FPG_RST_OV_RESP;
      ot_resp_q <= `FPG_RST_OT_RESP;
      neg_cfg_q <= `FPG_RST_NEG_LIMIT;
      valley_q <= `FPG_RST_VALLEY;
      out_ctrl_q <= `FPG_RST_OUT_CTRL;
      protect_q <= `FPG_RST_PROTECT;
      scale_seen_q <= 1'b0;
      pmbus_ref_q <= 1'b0;
    end else begin
      if (wr_hit(`FPG_CMD_VOUT_SCALE_LOOP)) begin
        scale_q <= cmd_data_i;
        scale_seen_q <= 1'b1;
      end
      if (wr_hit(`FPG_CMD_VOUT_COMMAND)) begin
        vout_mv_q <= cmd_data_i;
        pmbus_ref_q <= scale_seen_q;
      end
      if (wr_hit(`FPG_CMD_OV_RESPONSE)) begin
        ov_resp_q <= cmd_data_i[7:0];
      end
      if (wr_hit(`FPG_CMD_OT_RESPONSE)) begin
        ot_resp_q <= cmd_data_i[7:0];
      end
      if (wr_hit(`FPG_CMD_NEG_LIMIT)) begin
        neg_cfg_q <= cmd_data_i[7:0];
      end
      if (wr_hit(`FPG_CMD_VALLEY_LIMIT)) begin
        valley_q <= cmd_data_i[7:0];
      end
      if (wr_hit(`FPG_CMD_OUT_CTRL)) begin
        out_ctrl_q <= cmd_data_i[7:0];
      end
      if (wr_hit(`FPG_CMD_PROTECT_CFG)) begin
        protect_q <= cmd_data_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference computation
  // ----------------------------------------------------------------
  wire [31:0] vref_prod = vout_mv_q * scale_q;
  wire [16:0] vref_raw = vref_prod[31:`FPG_SCALE_FRAC];
  reg [9:0] vref_d;
  always @* begin
    vref_d = `FPG_VREF_DEF_MV;
    if (pmbus_ref_q) begin
      if (vref_raw < {7'h00, `FPG_VREF_MIN_MV}) begin
        vref_d = `FPG_VREF_MIN_MV;
      end else if (vref_raw > {7'h00, `FPG_VREF_MAX_MV}) begin
        vref_d = `FPG_VREF_MAX_MV;
      end else begin
        vref_d = vref_raw[9:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Trip detection
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg oc_seen_q;
  reg cycle_oc_q;
  reg [4:0] oc_count_q;
  wire active = (state_q == ST_SS) || (state_q == ST_RUN);
  wire oc_now = ls_s & oc_s;
  wire oc_cycle_hit = cycle_oc_q | oc_now;
  wire oc_count_trip = sw_edge && oc_cycle_hit && (oc_count_q == `FPG_OC_TRIP_CYCLES - 5'h01);
  wire oc_uv_trip = uv_s && (oc_seen_q || oc_now) && (state_q == ST_RUN);
  wire oc_trip = active && (oc_count_trip || oc_uv_trip);
  wire uv_trip = uv_s && (state_q == ST_RUN) && !oc_uv_trip;
  wire ov_trip = active && ov_s;
  wire ot_trip = active && ot_s;
  wire any_trip = oc_trip | uv_trip | ov_trip | ot_trip;
  wire go_latch = (oc_trip & protect_q[`FPG_PROT_OC_LATCH_BIT]) |
                  (uv_trip & protect_q[`FPG_PROT_UV_LATCH_BIT]) |
                  (ov_trip & ov_resp_q[`FPG_RESP_LATCH_BIT]) |
                  (ot_trip & ot_resp_q[`FPG_RESP_LATCH_BIT]);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sw_prev_q <= 1'b0;
      ls_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
      oc_seen_q <= 1'b0;
      cycle_oc_q <= 1'b0;
      oc_count_q <= 5'h00;
    end else begin
      sw_prev_q <= sw_s;
      ls_prev_q <= ls_s;
      hs_prev_q <= hs_s;
      if (oc_now) begin
        oc_seen_q <= 1'b1;
      end else if (ls_edge || !active) begin
        oc_seen_q <= 1'b0;
      end
      if (sw_edge) begin
        cycle_oc_q <= 1'b0;
      end else if (oc_now) begin
        cycle_oc_q <= 1'b1;
      end
      if (!active || oc_trip) begin
        oc_count_q <= 5'h00;
      end else if (sw_edge) begin
        oc_count_q <= oc_cycle_hit ? oc_count_q + 5'h01 : 5'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  reg ss_load;
  reg hic_load;
  wire ss_done;
  wire hic_done;
  always @* begin
    state_d = state_q;
    ss_load = 1'b0;
    hic_load = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (en_s && !lock_s) begin
          state_d = ST_SS;
          ss_load = 1'b1;
        end
      end
      ST_SS, ST_RUN: begin
        if (any_trip) begin
          state_d = go_latch ? ST_LATCH : ST_HICCUP;
          hic_load = !go_latch;
        end else if (state_q == ST_SS && ss_done) begin
          state_d = ST_RUN;
        end
      end
      ST_HICCUP: begin
        if (hic_done) begin
          state_d = ST_SS;
          ss_load = 1'b1;
        end
      end
      ST_LATCH: begin
        state_d = ST_LATCH;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!en_s || lock_s) begin
      state_d = ST_OFF;
      ss_load = 1'b0;
      hic_load = 1'b0;
    end
  end

  fpg_timer u_phase_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(ss_load | hic_load),
    .abort_i(state_d == ST_OFF),
    .count_i(ss_load ? SS_CYCLES[23:0] : HICCUP_CYCLES[23:0]),
    .done_o(ss_done)
  );
  assign hic_done = ss_done;

  // ----------------------------------------------------------------
  // Power-ok delay
  // ----------------------------------------------------------------
  reg pg_latch_q;
  reg pg_wait_q;
  wire pg_done;
  wire pg_start = (state_q == ST_RUN) && pgon_s && !pg_wait_q && !power_ok_o && !pg_latch_q;
  wire [25:0] pg_delay = PG_STEP_CYCLES[23:0] * ({1'b0, out_ctrl_q[1:0]} + 3'h1);

  fpg_timer u_pg_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(pg_start),
    .abort_i(pg_latch_q),
    .count_i(pg_delay[23:0]),
    .done_o(pg_done)
  );

  // ----------------------------------------------------------------
  // Outputs, status and read-back
  // ----------------------------------------------------------------
  reg [4:0] neg_cnt_q;
  wire [4:0] neg_blank = neg_cfg_q[`FPG_NEG_BLANK_SEL_BIT] ?
                         `FPG_NEG_BLANK_LONG_CYC : `FPG_NEG_BLANK_SHORT_CYC;
  wire [4:0] fault_set = {lock_s, ot_trip, ov_trip, uv_trip, oc_trip};
  wire st_clear = wr_hit(`FPG_CMD_FAULT_STATUS);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
      switching_en_o <= 1'b0;
      soft_start_o <= 1'b0;
      hs_allow_o <= 1'b0;
      ls_force_off_o <= 1'b0;
      output_sink_state_o <= 1'b0;
      neg_limit_sel_o <= 1'b0;
      valley_limit_o <= `FPG_RST_VALLEY;
      vref_mv_o <= `FPG_VREF_DEF_MV;
      power_ok_o <= 1'b0;
      power_ok_oe_o <= 1'b1;
      pg_latch_q <= 1'b0;
      pg_wait_q <= 1'b0;
      neg_cnt_q <= 5'h00;
      fault_status_o <= 5'h00;
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      state_q <= state_d;
      switching_en_o <= (state_d == ST_SS) || (state_d == ST_RUN);
      soft_start_o <= (state_d == ST_SS);
      hs_allow_o <= ((state_d == ST_SS) || (state_d == ST_RUN)) && !oc_now &&
                    !(oc_seen_q && !ls_edge);
      if (neg_s && ls_s && active) begin
        neg_cnt_q <= neg_blank;
        ls_force_off_o <= 1'b1;
      end else if (neg_cnt_q != 5'h00) begin
        neg_cnt_q <= neg_cnt_q - 5'h01;
        ls_force_off_o <= (neg_cnt_q != 5'h01);
      end else begin
        ls_force_off_o <= 1'b0;
      end
      neg_limit_sel_o <= neg_cfg_q[`FPG_NEG_LIMIT_SEL_BIT];
      valley_limit_o <= valley_q;
      vref_mv_o <= vref_d;
      if (hs_edge || !active) begin
        output_sink_state_o <= 1'b0;
      end else if (sink_s && !ov_s) begin
        output_sink_state_o <= 1'b1;
      end
      if (any_trip || lock_s) begin
        pg_latch_q <= 1'b1;
      end else if (ss_load) begin
        pg_latch_q <= 1'b0;
      end
      if (pg_start) begin
        pg_wait_q <= 1'b1;
      end else if (pg_done || pg_latch_q || state_q != ST_RUN) begin
        pg_wait_q <= 1'b0;
      end
      if (any_trip || lock_s || pg_latch_q || state_q != ST_RUN) begin
        power_ok_o <= 1'b0;
        power_ok_oe_o <= 1'b1;
      end else if (pg_done && pg_wait_q) begin
        power_ok_o <= 1'b1;
        power_ok_oe_o <= 1'b0;
      end
      fault_status_o <= fault_set | (fault_status_o & ~(st_clear ? cmd_data_i[4:0] : 5'h00));
      rd_valid_o <= cmd_rd_i;
      if (cmd_rd_i) begin
        case (cmd_code_i)
          `FPG_CMD_VOUT_COMMAND: rd_data_o <= vout_mv_q;
          `FPG_CMD_VOUT_SCALE_LOOP: rd_data_o <= scale_q;
          `FPG_CMD_OV_RESPONSE: rd_data_o <= {8'h00, ov_resp_q};
          `FPG_CMD_OT_RESPONSE: rd_data_o <= {8'h00, ot_resp_q};
          `FPG_CMD_NEG_LIMIT: rd_data_o <= {8'h00, neg_cfg_q};
          `FPG_CMD_VALLEY_LIMIT: rd_data_o <= {8'h00, valley_q};
          `FPG_CMD_OUT_CTRL: rd_data_o <= {8'h00, out_ctrl_q};
          `FPG_CMD_PROTECT_CFG: rd_data_o <= {8'h00, protect_q};
          `FPG_CMD_FAULT_STATUS: rd_data_o <= {11'h000, fault_status_o};
          default: rd_data_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ### bench/fpg_props.sv
// Port-level checker bound to the supervisor.
// Assumes the timing parameters of the bound instance are handed on.
`timescale 1ns/1ns
module fpg_props #(
  parameter SS_CYCLES = 50,
  parameter HICCUP_CYCLES = 80,
  parameter PG_STEP_CYCLES = 20
) (
  input wire clock_i,
  input wire rst_i,
  input wire ls_on_i,
  input wire hs_on_i,
  input wire oc_cmp_i,
  input wire neg_cmp_i,
  input wire ov_cmp_i,
  input wire sink_cmp_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_data_i,
  input wire rd_valid_o,
  input wire switching_en_o,
  input wire soft_start_o,
  input wire hs_allow_o,
  input wire ls_force_off_o,
  input wire output_sink_state_o,
  input wire [7:0] valley_limit_o,
  input wire [9:0] vref_mv_o,
  input wire power_ok_o,
  input wire power_ok_oe_o,
  input wire [4:0] fault_status_o
);
  logic [4:0] neg_q, snk_q;
  logic [1:0] clr_q;
  logic [31:0] run_q;
  // Recent causes and the length of the current run state.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      neg_q <= 5'h00;
      snk_q <= 5'h00;
      clr_q <= 2'h0;
      run_q <= 32'h0;
    end else begin
      neg_q <= {neg_q[3:0], neg_cmp_i & ls_on_i};
      snk_q <= {snk_q[3:0], sink_cmp_i & !ov_cmp_i};
      clr_q <= {clr_q[0], cmd_wr_i && cmd_code_i == 8'he3};
      run_q <= (switching_en_o && !soft_start_o) ? run_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_pok_oe; power_ok_oe_o == !power_ok_o; endproperty
  a_pok_oe: assert property (p_pok_oe) else $error("power ok enable wrong");
  property p_trip; |(fault_status_o & ~$past(fault_status_o)) |-> ##[0:1] !power_ok_o; endproperty
  a_trip: assert property (p_trip) else $error("power ok not dropped");
  property p_pok_dly; $rose(power_ok_o) |-> run_q >= PG_STEP_CYCLES - 1; endproperty
  a_pok_dly: assert property (p_pok_dly) else $error("power ok early");
  property p_off; $fell(switching_en_o) |=> !switching_en_o [*8]; endproperty
  a_off: assert property (p_off) else $error("restart too soon");
  property p_hs; (oc_cmp_i && ls_on_i && switching_en_o) [*6] |-> !hs_allow_o; endproperty
  a_hs: assert property (p_hs) else $error("high side allowed");
  property p_neg; $rose(ls_force_off_o) |-> neg_q != 5'h00 ##0 ls_force_off_o [*8]; endproperty
  a_neg: assert property (p_neg) else $error("blanking wrong");
  property p_snk; $rose(output_sink_state_o) |-> snk_q != 5'h00; endproperty
  a_snk: assert property (p_snk) else $error("sink without cause");
  property p_snk_x; output_sink_state_o && $rose(hs_on_i) |-> ##[1:6] !output_sink_state_o;
  endproperty
  a_snk_x: assert property (p_snk_x) else $error("sink not left");
  property p_vref; vref_mv_o >= 10'h1f4 && vref_mv_o <= 10'h2a0; endproperty
  a_vref: assert property (p_vref) else $error("reference out of range");
  property p_valley; cmd_wr_i && cmd_code_i == 8'hd7 |->
    ##2 {8'h00, valley_limit_o} == ($past(cmd_data_i, 2) & 16'h00ff); endproperty
  a_valley: assert property (p_valley) else $error("valley limit wrong");
  property p_sticky; |($past(fault_status_o) & ~fault_status_o) |-> clr_q != 2'h0; endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  property p_rd; rd_valid_o == $past(cmd_rd_i); endproperty
  a_rd: assert property (p_rd) else $error("read valid wrong");
  c_pok: cover property ($rose(power_ok_o));
  c_sink: cover property ($rose(output_sink_state_o));
  c_oc: cover property ($rose(fault_status_o[0]));
endmodule

bind fpg_supervisor fpg_props #(.SS_CYCLES(SS_CYCLES), .HICCUP_CYCLES(HICCUP_CYCLES),
  .PG_STEP_CYCLES(PG_STEP_CYCLES)) i_fpg_props (.clock_i(clock_i), .rst_i(rst_i),
  .ls_on_i(ls_on_i), .hs_on_i(hs_on_i), .oc_cmp_i(oc_cmp_i), .neg_cmp_i(neg_cmp_i),
  .ov_cmp_i(ov_cmp_i), .sink_cmp_i(sink_cmp_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
  .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rd_valid_o(rd_valid_o),
  .switching_en_o(switching_en_o), .soft_start_o(soft_start_o), .hs_allow_o(hs_allow_o),
  .ls_force_off_o(ls_force_off_o), .output_sink_state_o(output_sink_state_o),
  .valley_limit_o(valley_limit_o), .vref_mv_o(vref_mv_o), .power_ok_o(power_ok_o),
  .power_ok_oe_o(power_ok_oe_o), .fault_status_o(fault_status_o));

// ### bench/fpg_host_model.sv
// Management host model driving the decoded command strobes.
// Assumes requests launch just after a rising core clock edge.
`timescale 1ns/1ns
module fpg_host_model (
  input wire clock_i,
  output logic cmd_wr_o,
  output logic cmd_rd_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_data_o
);
  initial begin
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_data_o = 16'h0000;
  end
  // One strobe cycle; released lines show the inverse of the last value.
  task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d);
    @(posedge clock_i);
    cmd_wr_o <= !rd;
    cmd_rd_o <= rd;
    cmd_code_o <= c;
    cmd_data_o <= d;
    @(posedge clock_i);
    cmd_wr_o <= 1'b0;
    cmd_rd_o <= 1'b0;
    cmd_code_o <= ~c;
    cmd_data_o <= ~d;
  endtask
  task automatic set_vout(input logic [15:0] g, input logic [15:0] mv);
    xfer(1'b0, 8'h29, g);
    xfer(1'b0, 8'h21, mv);
  endtask
endmodule

// ### bench/fpg_supervisor_tb.sv
// Self-checking bench of the supervisor with a host model on the command port.
// Assumes shortened soft-start, hiccup and power-ok step counts.
`timescale 1ns/1ns
module fpg_supervisor_tb;
  logic clock_i, rst_i, sw_clk, sw_run, ls_on, hs_on, oc, neg, sink, pgc, en;
  logic cmd_wr, cmd_rd, rd_valid, sw_en, ss, hs_allow, ls_off, sink_st, nsel, pok, pok_oe;
  logic [3:0] tv;
  logic [7:0] code, valley;
  logic [15:0] data, rd_data, v;
  logic [9:0] vref;
  logic [4:0] fst;
  logic [15:0] exq[$];
  logic [15:0] sc[4] = '{16'h8000, 16'h8000, 16'h8000, 16'h4000};
  logic [15:0] mv[4] = '{16'h02bc, 16'h0190, 16'h028a, 16'h04b0};
  logic [15:0] ev[4] = '{16'h02a0, 16'h01f4, 16'h028a, 16'h0258};
  int miscompares = 0;
  int checks = 0;
  int seed = 29;
  wire pg_pin = !pok_oe;
  wire [2:0] obs = {sink_st, pok, sw_en};
  fpg_supervisor #(.SS_CYCLES(50), .HICCUP_CYCLES(80), .PG_STEP_CYCLES(20)) i_fpg_supervisor (
    .clock_i(clock_i), .rst_i(rst_i), .sw_clk_i(sw_clk), .ls_on_i(ls_on), .hs_on_i(hs_on),
    .oc_cmp_i(oc), .neg_cmp_i(neg), .uv_cmp_i(tv[0]), .ov_cmp_i(tv[1]), .sink_cmp_i(sink),
    .ot_cmp_i(tv[2]), .pg_on_cmp_i(pgc), .lockout_i(tv[3]), .enable_pin_i(en),
    .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_code_i(code), .cmd_data_i(data),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .switching_en_o(sw_en), .soft_start_o(ss),
    .hs_allow_o(hs_allow), .ls_force_off_o(ls_off), .output_sink_state_o(sink_st),
    .neg_limit_sel_o(nsel), .valley_limit_o(valley), .vref_mv_o(vref), .power_ok_o(pok),
    .power_ok_oe_o(pok_oe), .fault_status_o(fst));
  fpg_host_model i_fpg_host_model (.clock_i(clock_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
    .cmd_code_o(code), .cmd_data_o(data));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Switching marker of 125 ns, still while not running.
  initial begin
    sw_clk = 1'b0;
    #1;
    forever begin
      #63 sw_clk = sw_run;
      #62 sw_clk = 1'b0;
    end
  end
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exq.push_back(e);
    i_fpg_host_model.xfer(1'b1, c, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_fpg_host_model.xfer(1'b0, c, d);
  endtask
  task automatic wt(input int k);
    int n;
    n = 0;
    while (obs[k] !== 1'b1 && n < 1000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 1000) begin
      chk("wait", 16'h0000, 16'h0001);
      test_done();
    end
  endtask
  always @(posedge clock_i) begin
    if (rd_valid === 1'b1) begin
      if (exq.size() > 0) chk("read data", exq.pop_front(), rd_data);
      else chk("read count", 16'h0000, 16'h0001);
    end
  end
  initial begin
    {sw_run, ls_on, hs_on, oc, neg, sink, pgc, en, tv} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'hd7, 16'h0040);
    rd(8'h21, 16'h0258);
    rd(8'hd5, 16'h0000);
    rd(8'h00, 16'h0000);
    chk("vref", 16'h0258, {6'h00, vref});
    v = 16'($random(seed)) & 16'h00ff;
    wr(8'hd7, v);
    rd(8'hd7, v);
    repeat (2) @(posedge clock_i);
    chk("valley", v, {8'h00, valley});
    for (int i = 0; i < 4; i++) begin
      i_fpg_host_model.set_vout(sc[i], mv[i]);
      repeat (4) @(posedge clock_i);
      chk("vref", ev[i], {6'h00, vref});
    end
    wr(8'he1, 16'h0001);
    rd(8'he1, 16'h0001);
    pgc <= 1'b1;
    en <= 1'b1;
    wt(0);
    repeat (80) @(posedge clock_i);
    chk("pok early", 16'h0000, {15'h0000, pok});
    wt(1);
    chk("pg pin", 16'h0001, {15'h0000, pg_pin});
    sink <= 1'b1;
    wt(2);
    sink <= 1'b0;
    hs_on <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("sink", 16'h0000, {15'h0000, sink_st});
    hs_on <= 1'b0;
    ls_on <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(8'hd5, i ? 16'h000c : 16'h0000);
      neg <= 1'b1;
      @(posedge clock_i);
      neg <= 1'b0;
      repeat (i ? 14 : 6) @(posedge clock_i);
      chk("blank on", 16'h0001, {15'h0000, ls_off});
      repeat (20) @(posedge clock_i);
      chk("blank off", 16'h0000, {15'h0000, ls_off});
    end
    chk("neg sel", 16'h0001, {15'h0000, nsel});
    sw_run <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(negedge sw_clk);
      oc <= 1'b1;
      repeat (i ? 40 : 29) @(negedge sw_clk);
      oc <= 1'b0;
      repeat (3) @(posedge sw_clk);
      rd(8'he3, {15'h0000, i[0]});
    end
    wr(8'he3, 16'h001f);
    rd(8'he3, 16'h0000);
    wt(1);
    @(negedge sw_clk);
    oc <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("hs allow", 16'h0000, {15'h0000, hs_allow});
    tv <= 4'h1;
    repeat (8) @(posedge clock_i);
    oc <= 1'b0;
    tv <= 4'h0;
    rd(8'he3, 16'h0001);
    wr(8'he3, 16'h001f);
    ls_on <= 1'b0;
    repeat (4) @(posedge clock_i);
    ls_on <= 1'b1;
    wr(8'he2, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      wt(1);
      tv <= 4'h1 << i;
      repeat (16) @(posedge clock_i);
      chk("pok trip", 16'h0000, {15'h0000, pok});
      tv <= 4'h0;
      rd(8'he3, 16'h0002 << i);
      wr(8'he3, 16'h001f);
      repeat (300) @(posedge clock_i);
      chk("switching", 16'(i >= 2), {15'h0000, sw_en});
      en <= 1'b0;
      repeat (20) @(posedge clock_i);
      en <= 1'b1;
    end
    wt(1);
    chk("pending", 16'h0000, 16'(exq.size()));
    test_done();
  end
endmodule
